/* hdl/mcpmc_pkg.sv */
// package: register layout, reset values and mode types of the clock and power mode control
package mcpmc_pkg;

  localparam int          MCPMC_CPS_LSB      = 0;
  localparam int          MCPMC_CPS_W        = 3;
  localparam int          MCPMC_AUTO_BIT     = 3;
  localparam int          MCPMC_BCE_BIT      = 4;
  localparam logic [7:0]  MCPMC_CCTL_RESET   = 8'h10;
  localparam logic [7:0]  MCPMC_CCTL_WMASK   = 8'h1F;
  localparam int          MCPMC_PWR_IDLE_BIT = 0;
  localparam int          MCPMC_PWR_PD_BIT   = 1;
  localparam logic [7:0]  MCPMC_PWR_RESET    = 8'h00;
  localparam logic [7:0]  MCPMC_PWR_WMASK    = 8'h03;
  localparam int          MCPMC_RESTART_MCYC = 3;
  localparam int          MCPMC_CLK_PER_MCYC = 4;
  localparam int          MCPMC_RESTART_CYC  = MCPMC_RESTART_MCYC * MCPMC_CLK_PER_MCYC;
  localparam int          MCPMC_DIV_W        = 11;

  typedef enum logic [1:0] {
    MCPMC_RUN     = 2'b00,
    MCPMC_IDLE    = 2'b01,
    MCPMC_PDOWN   = 2'b11,
    MCPMC_RESTART = 2'b10
  } mcpmc_mode_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } mcpmc_sfr_t;

endpackage

/* hdl/mcpmc_top.sv */
// top: core clock prescaler, clock gating and idle / power-down sequencing
//
// What this block does
// RL1: divide code selects oscillator divide 1..2048
// RL2: comparator enable bit 4, one after reset
// RL3: idle stops core clock, peripherals run
// RL4: idle keeps peripherals, supervisor resets armed
// RL5: watchdog clock gated during idle
// RL6: firmware should disable unused peripherals first
// RL7: interrupt or supervisor reset ends idle
// RL8: port outputs hold during idle
// RL9: idle starts after the setting write
// RL10: core state frozen while idle
// RL11: enabled interrupt clears idle bit, serviced
// RL12: execution resumes after the idle write
// RL13: supervisor reset restarts core after three machine cycles
// RL14: power-down stops core and peripheral clocks
// RL15: power-down write is last, oscillator stops
// RL16: registers and memory kept in power-down
// RL17: only supervisor resets leave power-down
// RL18: no watchdog reset during power-down
// RL19: auto-restore forces divide code zero
// RL20: new divide code acts immediately
// RL21: peripheral clock undivided, stops only powered down
// RL22: idle or power-down bit gates core clock
// RL23: gating changes leave no truncated pulses
// RL24: three reserved upper bits read zero
`timescale 1ns/1ps
module mcpmc_top
  import mcpmc_pkg::*;
#(
  parameter int RESTART_CYCLES = MCPMC_RESTART_CYC
) (
  input  wire logic       core_clk_in,
  input  wire logic       rst_in,
  input  wire mcpmc_sfr_t cctl_bus_in,
  input  wire mcpmc_sfr_t pwr_bus_in,
  input  wire logic       irq_req_in,
  input  wire logic       sup_reset_in,
  input  wire logic [7:0] port_drive_in,
  output logic [7:0]      cctl_rdata_out,
  output logic [7:0]      pwr_rdata_out,
  output logic            core_clk_en_out,
  output logic            watchdog_clk_en_out,
  output logic            peripheral_clk_en_out,
  output logic            osc_run_out,
  output logic            core_hold_out,
  output logic            core_reset_out,
  output logic            breakpoint_comparator_enable_out,
  output logic [7:0]      port_level_out
);

  logic [2:0]             divide_code_q;
  logic                   auto_restore_q;
  logic                   bce_q;
  logic                   idle_bit_q;
  logic                   pd_bit_q;
  mcpmc_mode_t            mode_q;
  logic [MCPMC_DIV_W-1:0] div_cnt_q;
  logic [MCPMC_DIV_W-1:0] div_mask;
  logic                   tick;
  logic [7:0]             restart_q;
  logic                   core_run;
  logic                   cctl_write;
  logic                   restore_hit;
  logic                   pwr_write;
  logic                   pd_request;
  logic                   idle_request;
  logic                   restart_done;
  logic                   in_run;
  logic                   in_idle;
  logic                   in_pdown;
  logic                   in_restart;
  logic [7:0]             cctl_image;
  logic [7:0]             pwr_image;

  // mode decode shared by the register, sequencing and output logic
  assign in_run     = (mode_q == MCPMC_RUN);
  assign in_idle    = (mode_q == MCPMC_IDLE);
  assign in_pdown   = (mode_q == MCPMC_PDOWN);
  assign in_restart = (mode_q == MCPMC_RESTART);

  // clock control writes are refused while the oscillator is stopped
  assign cctl_write  = cctl_bus_in.wr && !in_pdown;
  assign restore_hit = auto_restore_q && irq_req_in && !in_pdown;

  // power-down wins over idle when firmware sets both bits in one write
  assign pwr_write    = pwr_bus_in.wr && in_run;
  assign pd_request   = pwr_write && pwr_bus_in.wdata[MCPMC_PWR_PD_BIT];
  assign idle_request = pwr_write && !pwr_bus_in.wdata[MCPMC_PWR_PD_BIT]
                        && pwr_bus_in.wdata[MCPMC_PWR_IDLE_BIT];
  assign restart_done = (restart_q <= 8'h01);

  // divider runs on the oscillator; the tick is a whole-cycle enable, so no pulse is cut
  always_comb begin
    case (divide_code_q)
      3'h0: begin
        div_mask = 11'h000;
      end
      3'h1: begin
        div_mask = 11'h001;
      end
      3'h2: begin
        div_mask = 11'h003;
      end
      3'h3: begin
        div_mask = 11'h007;
      end
      3'h4: begin
        div_mask = 11'h00F;
      end
      3'h5: begin
        div_mask = 11'h01F;
      end
      3'h6: begin
        div_mask = 11'h3FF;
      end
      default: begin
        div_mask = 11'h7FF;
      end
    endcase
  end // RL1

  // restarting the count on a code write lets the new ratio act at once
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_cnt_q <= '0;
    end else if (cctl_bus_in.wr || tick) begin
      div_cnt_q <= '0; // RL20
    end else begin
      div_cnt_q <= div_cnt_q + 11'h001;
    end
  end

  assign tick     = ((div_cnt_q & div_mask) == div_mask); // RL23
  assign core_run = in_run && !idle_bit_q && !pd_bit_q; // RL22

  assign cctl_image = {3'b000, bce_q, auto_restore_q, divide_code_q}; // RL24
  assign pwr_image  = {6'b000000, pd_bit_q, idle_bit_q};

  // divide code; with auto-restore set, a pending interrupt beats a same-cycle write of the code
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      divide_code_q <= MCPMC_CCTL_RESET[2:0];
    end else if (sup_reset_in) begin
      divide_code_q <= MCPMC_CCTL_RESET[2:0];
    end else if (restore_hit) begin
      divide_code_q <= 3'h0; // RL19
    end else if (cctl_write) begin
      divide_code_q <= cctl_bus_in.wdata[2:0]; // RL1
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      auto_restore_q <= MCPMC_CCTL_RESET[MCPMC_AUTO_BIT];
    end else if (sup_reset_in) begin
      auto_restore_q <= MCPMC_CCTL_RESET[MCPMC_AUTO_BIT];
    end else if (cctl_write) begin
      auto_restore_q <= cctl_bus_in.wdata[MCPMC_AUTO_BIT];
    end
  end

  // comparators come back enabled after every reset, supervisor reset included
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      bce_q <= MCPMC_CCTL_RESET[MCPMC_BCE_BIT]; // RL2
    end else if (sup_reset_in) begin
      bce_q <= MCPMC_CCTL_RESET[MCPMC_BCE_BIT]; // RL2
    end else if (cctl_write) begin
      bce_q <= cctl_bus_in.wdata[MCPMC_BCE_BIT];
    end
  end

  // idle bit; set by the write, cleared by the waking interrupt
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      idle_bit_q <= MCPMC_PWR_RESET[MCPMC_PWR_IDLE_BIT];
    end else if (sup_reset_in) begin
      idle_bit_q <= 1'b0; // RL7 RL13
    end else if (idle_request) begin
      idle_bit_q <= 1'b1; // RL9
    end else if (in_idle && irq_req_in) begin
      idle_bit_q <= 1'b0; // RL11
    end
  end

  // power-down bit; only a supervisor reset clears it
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pd_bit_q <= MCPMC_PWR_RESET[MCPMC_PWR_PD_BIT];
    end else if (sup_reset_in) begin
      pd_bit_q <= 1'b0; // RL17
    end else if (pd_request) begin
      pd_bit_q <= 1'b1; // RL15
    end
  end

  // restart counter, loaded on every supervisor reset
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      restart_q <= 8'h00;
    end else if (sup_reset_in) begin
      restart_q <= 8'(RESTART_CYCLES); // RL13
    end else if (in_restart && restart_done) begin
      restart_q <= 8'h00;
    end else if (in_restart) begin
      restart_q <= restart_q - 8'h01;
    end
  end

  // mode sequencing; the write itself completes before the halt takes hold
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      mode_q <= MCPMC_RUN;
    end else if (sup_reset_in) begin
      mode_q <= MCPMC_RESTART; // RL13
    end else begin
      case (mode_q)
        MCPMC_RUN: begin
          if (pd_request) begin
            mode_q <= MCPMC_PDOWN; // RL15
          end else if (idle_request) begin
            mode_q <= MCPMC_IDLE; // RL9
          end
        end
        MCPMC_IDLE: begin
          if (irq_req_in) begin
            mode_q <= MCPMC_RUN; // RL7 RL12
          end
        end
        MCPMC_PDOWN: begin
          mode_q <= MCPMC_PDOWN; // RL17
        end
        MCPMC_RESTART: begin
          if (restart_done) begin
            mode_q <= MCPMC_RUN;
          end
        end
        default: begin
          mode_q <= MCPMC_RUN;
        end
      endcase
    end
  end

  // enables are high for the cycle a gated clock may fire
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      core_clk_en_out <= 1'b0;
    end else begin
      core_clk_en_out <= core_run && tick; // RL3
    end
  end

  // the watchdog shares the gated core clock, so it stops in both low-power modes
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      watchdog_clk_en_out <= 1'b0;
    end else begin
      watchdog_clk_en_out <= core_run && tick; // RL5 RL18
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      peripheral_clk_en_out <= 1'b0;
    end else begin
      peripheral_clk_en_out <= !in_pdown; // RL21 RL14 RL4
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      osc_run_out <= 1'b1;
    end else begin
      osc_run_out <= !in_pdown; // RL15
    end
  end

  // hold freezes all core state; it drops once the mode leaves idle or power-down
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      core_hold_out <= 1'b0;
    end else begin
      core_hold_out <= in_idle || in_pdown; // RL10 RL16
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      core_reset_out <= 1'b1;
    end else begin
      core_reset_out <= sup_reset_in || in_restart; // RL13
    end
  end

  // each port bit holds on its own; a bit only follows the core in run
  for (genvar b = 0; b < 8; b++) begin : g_port
    always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
        port_level_out[b] <= 1'b1;
      end else if (in_run) begin
        port_level_out[b] <= port_drive_in[b]; // RL8
      end
    end
  end

  // read images lag the registers by one cycle
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cctl_rdata_out <= MCPMC_CCTL_RESET;
    end else begin
      cctl_rdata_out <= cctl_image; // RL24
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pwr_rdata_out <= MCPMC_PWR_RESET;
    end else begin
      pwr_rdata_out <= pwr_image;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      breakpoint_comparator_enable_out <= 1'b1;
    end else begin
      breakpoint_comparator_enable_out <= bce_q; // RL2
    end
  end

endmodule

/* tb/mcpmc_asserts.sv */
// checker: timing relations at the ports of the clock and power mode control
`timescale 1ns/1ps
module mcpmc_asserts
  import mcpmc_pkg::*;
#(
  parameter int RESTART_CYCLES = MCPMC_RESTART_CYC
) (
  input wire logic       core_clk_in,
  input wire logic       rst_in,
  input wire mcpmc_sfr_t pwr_bus_in,
  input wire logic       irq_req_in,
  input wire logic       sup_reset_in,
  input wire logic [7:0] cctl_rdata_out,
  input wire logic [7:0] pwr_rdata_out,
  input wire logic       core_clk_en_out,
  input wire logic       watchdog_clk_en_out,
  input wire logic       peripheral_clk_en_out,
  input wire logic       osc_run_out,
  input wire logic       core_hold_out,
  input wire logic       core_reset_out,
  input wire logic       breakpoint_comparator_enable_out,
  input wire logic [7:0] port_level_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  localparam int RW = RESTART_CYCLES + 4;
  sequence s_idle_wr;
    pwr_bus_in.wr && pwr_bus_in.wdata[1:0] == 2'h1 && !core_hold_out && !core_reset_out;
  endsequence
  sequence s_idle_on;
    core_hold_out && !core_clk_en_out && peripheral_clk_en_out;
  endsequence
  property p_idle; s_idle_wr |-> ##2 s_idle_on; endproperty
  property p_gate; core_hold_out |-> !core_clk_en_out && !watchdog_clk_en_out; endproperty
  property p_port; core_hold_out && $past(core_hold_out) |-> $stable(port_level_out); endproperty
  property p_pd; !osc_run_out |-> !peripheral_clk_en_out && !watchdog_clk_en_out; endproperty
  property p_bce; $fell(rst_in) |-> breakpoint_comparator_enable_out; endproperty
  property p_rst; $rose(sup_reset_in) |-> ##[1:2] core_reset_out ##[1:RW] !core_reset_out;
  endproperty
  property p_keep; pwr_rdata_out[1] && !sup_reset_in && !$past(sup_reset_in) |=>
    pwr_rdata_out[1]; endproperty
  property p_rest; cctl_rdata_out[3] && irq_req_in && !core_hold_out && !core_reset_out |->
    ##2 cctl_rdata_out[2:0] == 3'h0; endproperty
  a_idle: assert property (p_idle) else $error("idle entry wrong");
  a_gate: assert property (p_gate) else $error("core clock not gated");
  a_port: assert property (p_port) else $error("port moved in hold");
  a_pd: assert property (p_pd) else $error("clock runs with oscillator off");
  a_bce: assert property (p_bce) else $error("comparator enable low after reset");
  a_rst: assert property (p_rst) else $error("restart length wrong");
  a_keep: assert property (p_keep) else $error("power-down left");
  a_rest: assert property (p_rest) else $error("auto restore missed");
endmodule
bind mcpmc_top mcpmc_asserts #(.RESTART_CYCLES(RESTART_CYCLES)) mcpmc_asserts_i (.*);

/* tb/mcpmc_core_model.sv */
// core-side model: a port pattern that moves every cycle and registered interrupt requests
`timescale 1ns/1ps
module mcpmc_core_model (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       irq_cmd_in,
  output logic            irq_req_out,
  output logic [7:0]      port_drive_out
);
  // the pattern never rests, so any leak through a held port shows at once
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      port_drive_out <= 8'hA5;
      irq_req_out    <= 1'b0;
    end else begin
      port_drive_out <= port_drive_out + 8'h01;
      irq_req_out    <= irq_cmd_in;
    end
  end
endmodule

/* tb/mcpmc_top_test.sv */
// self-checking bench for the clock and power mode control
`timescale 1ns/1ps
module mcpmc_top_test;
  import mcpmc_pkg::*;
  logic        clk, rst, irq_cmd, sup, irq, cen, wen, pen, osc, hold, crst, bce;
  mcpmc_sfr_t  cbus, pbus;
  logic [7:0]  drive, crd, prd, plv, p0;
  logic [31:0] seed;
  int          err_count, num_checks, n;
  mcpmc_core_model mcpmc_core_model_i (.clk_in(clk), .rst_in(rst), .irq_cmd_in(irq_cmd),
    .irq_req_out(irq), .port_drive_out(drive));
  mcpmc_top #(.RESTART_CYCLES(2)) mcpmc_top_i (.core_clk_in(clk), .rst_in(rst),
    .cctl_bus_in(cbus), .pwr_bus_in(pbus), .irq_req_in(irq), .sup_reset_in(sup),
    .port_drive_in(drive), .cctl_rdata_out(crd), .pwr_rdata_out(prd), .core_clk_en_out(cen),
    .watchdog_clk_en_out(wen), .peripheral_clk_en_out(pen), .osc_run_out(osc),
    .core_hold_out(hold), .core_reset_out(crst), .breakpoint_comparator_enable_out(bce),
    .port_level_out(plv));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  function automatic int ticks(input logic [2:0] c);
    return 8192 >> (c > 3'h5 ? int'(c) + 4 : int'(c));
  endfunction
  task automatic chk(input string w, input logic [19:0] e, input logic [19:0] s);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s exp %0h got %0h", w, e, s);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic p, input logic [7:0] d);
    @(posedge clk);
    if (p) pbus <= '{1'b1, 1'b0, d};
    else cbus <= '{1'b1, 1'b0, d};
    @(posedge clk);
    pbus.wr <= 1'b0;
    cbus.wr <= 1'b0;
    cyc(2);
  endtask
  // the model registers the request, so it reaches the design one cycle late
  task automatic pulse();
    @(posedge clk);
    irq_cmd <= 1'b1;
    @(posedge clk);
    irq_cmd <= 1'b0;
    cyc(4);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (50000) @(posedge clk);
    err_count++;
    give_verdict();
  end
  initial begin
    {irq_cmd, sup, cbus, pbus, rst} = '0;
    rst = 1'b1;
    seed = 32'h41F8;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    cyc(1);
    chk("reset", 20'h01000, {crd, prd});
    for (int c = 0; c < 8; c++) begin
      seed = xs(seed);
      wr(1'b0, {seed[7:5], 2'b10, 3'(c)});
      chk("cctl", 20'(8'h10 | 8'(c)), crd);
      n = 0;
      repeat (4096) begin
        cyc(1);
        n += cen + wen;
      end
      chk("ticks", 20'(ticks(3'(c))), 20'(n));
    end
    wr(1'b0, 8'h0D);
    chk("bce", 20'h0, bce);
    pulse();
    chk("restore", 20'h08, crd);
    wr(1'b1, 8'h01);
    p0 = plv;
    n = 0;
    repeat (40) begin
      cyc(1);
      n += cen + wen + (plv !== p0) + (pen !== 1'b1) + (hold !== 1'b1);
    end
    chk("idle", 20'h0, 20'(n));
    pulse();
    chk("wake", 20'h0, {hold, prd});
    wr(1'b1, 8'h02);
    chk("pd", 20'h002, {osc, pen, prd});
    pulse();
    wr(1'b1, 8'h00);
    chk("pd kept", 20'h2, prd);
    @(posedge clk);
    sup <= 1'b1;
    @(posedge clk);
    sup <= 1'b0;
    n = 0;
    repeat (20) begin
      cyc(1);
      n += crst;
    end
    chk("restart", 20'h50010, {n != 0, 1'b0, osc, prd, crd});
    give_verdict();
  end
endmodule
